/* design/frf_pkg.sv */
package frf_pkg;

   // clock and time slot of the ramp stepper
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned SLOT_TIME_US    = 205000;
   localparam int unsigned SLOT_CYCLES_DEF = SLOT_TIME_US * 1000 / CLK_PERIOD_NS;

   // widths
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;
   localparam int DUTY_W = 8;
   localparam int NUM_CH = 3;

   // register indices; byte address is four times the index
   localparam logic [7:0]        CFG_INDEX  = 8'h62;
   localparam logic [7:0]        STAT_INDEX = 8'h70;
   localparam logic [ADDR_W-1:0] CFG_ADDR   = {CFG_INDEX, 2'h0};
   localparam logic [ADDR_W-1:0] STAT_ADDR  = {STAT_INDEX, 2'h0};
   localparam logic [7:0]        CFG_RESET  = 8'h00;

   // field positions of ramp_and_floor_config
   localparam int RAMP_CODE_LSB = 0;
   localparam int RAMP_CODE_W   = 3;
   localparam int RAMP_EN_BIT   = 3;
   localparam int SYNC_BIT      = 4;
   localparam int FLOOR_LSB     = 5;

   // field positions of the status register
   localparam int STAT_DUTY_LSB   = 0;
   localparam int STAT_ACTIVE_BIT = 8;

   localparam logic [DUTY_W-1:0] DUTY_OFF = 8'h00;
   localparam logic [1:0]        SYNC_FIXED = 2'h3;

   typedef enum logic [1:0] {
      FRF_BUS_IDLE = 2'b01,
      FRF_BUS_ACK  = 2'b10
   } frf_bus_state_t;

   // duty step per time slot for each ramp code
   function automatic logic [DUTY_W-1:0] frf_step(input logic [RAMP_CODE_W-1:0] code);
      logic [DUTY_W-1:0] s;
      s = 8'h01;
      case (code)
         3'h0: s = 8'h01;
         3'h1: s = 8'h02;
         3'h2: s = 8'h03;
         3'h3: s = 8'h04;
         3'h4: s = 8'h08;
         3'h5: s = 8'h0C;
         3'h6: s = 8'h18;
         default: s = 8'h30;
      endcase
      return s;
   endfunction

endpackage

/* design/frf_ramp.sv */
`timescale 1ns/1ps
module frf_ramp #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_reset_n,
   // control side
   frf_ramp_if.ramp  rif
);
   logic [W-1:0] up_gap;
   logic [W-1:0] down_gap;

   assign up_gap   = rif.target - rif.duty;
   assign down_gap = rif.duty - rif.target;

   // steps both up and down so a falling target is also smoothed
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rif.duty <= '0;
      end else if (!rif.enable) begin
         rif.duty <= rif.target;                        // [RQ5]
      end else if (rif.tick && rif.duty < rif.target) begin
         rif.duty <= (up_gap > rif.step) ? rif.duty + rif.step : rif.target; // [RQ2]
      end else if (rif.tick && rif.duty > rif.target) begin
         rif.duty <= (down_gap > rif.step) ? rif.duty - rif.step : rif.target; // [RQ2]
      end
   end

   property p_bypass;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      !rif.enable |=> rif.duty == $past(rif.target);
   endproperty
   a_bypass: assert property (p_bypass) else $error("duty did not follow target"); // [RQ5]

   property p_hold;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      rif.enable && !rif.tick |=> $stable(rif.duty);
   endproperty
   a_hold: assert property (p_hold) else $error("duty moved between slots"); // [RQ2]

   property p_step_up;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      rif.enable && rif.tick && up_gap > rif.step && rif.duty < rif.target
      |=> rif.duty == W'($past(rif.duty) + $past(rif.step));
   endproperty
   a_step_up: assert property (p_step_up) else $error("ramp step size wrong"); // [RQ3]

   property p_reach;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      rif.enable && rif.tick
      && ((rif.duty < rif.target && up_gap <= rif.step)
          || (rif.duty > rif.target && down_gap <= rif.step))
      |=> rif.duty == $past(rif.target);
   endproperty
   a_reach: assert property (p_reach) else $error("ramp overshot or stalled"); // [RQ2]

   c_step: cover property (@(posedge i_core_clk) rif.enable && rif.tick && rif.duty != rif.target);

endmodule // frf_ramp

/* design/frf_ramp_if.sv */
`timescale 1ns/1ps
interface frf_ramp_if #(parameter int W = 8);
   logic         tick;
   logic         enable;
   logic [W-1:0] target;
   logic [W-1:0] step;
   logic [W-1:0] duty;

   modport ctrl (output tick, output enable, output target, output step, input duty);
   modport ramp (input tick, input enable, input target, input step, output duty);
endinterface

/* design/frf_slot_timer.sv */
`timescale 1ns/1ps
module frf_slot_timer #(
   parameter int unsigned CYCLES = 20500000
) (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_reset_n,
   // one-cycle pulse per time slot
   output logic      o_tick
);
   localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] count;

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count <= '0;
      end else if (count == LAST) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   assign o_tick = (count == LAST);

   property p_tick_gap;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      o_tick && (CYCLES > 1) |=> !o_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("slot tick lasted two cycles"); // [RQ3]

endmodule // frf_slot_timer

/* design/frf_top.sv */
// Contract
// RQ1: config bits 2..0 pick the ramp rate code for drive output one.
// RQ2: with ramping on, drive one steps toward the new duty, never jumps.
// RQ3: codes 0..7 step 1,2,3,4,8,12,24,48 duty counts per time slot.
// RQ4: ramping on drive one is active only while config bit 3 is one.
// RQ5: with bit 3 zero, drive one takes each new duty at once.
// RQ6: bit 4 one ties speed inputs two, three and four to drive three.
// RQ7: bit 4 zero ties only speed inputs three and four to drive three.
// RQ8: auto mode below start minus hysteresis: drive one off, or minimum if bit 5.
// RQ9: auto mode below start minus hysteresis: drive two off, or minimum if bit 6.
// RQ10: auto mode below start minus hysteresis: drive three off, or minimum if bit 7.
// RQ11: config register resets to all zeros.
// RQ12: while the global lock is set, writes to config are ignored.
`timescale 1ns/1ps
module frf_top #(
   parameter int unsigned SLOT_CYCLES = frf_pkg::SLOT_CYCLES_DEF
) (
   // clock and reset
   input  wire logic                                   i_core_clk,
   input  wire logic                                   i_reset_n,
   // avalon-mm slave
   input  wire logic [frf_pkg::ADDR_W-1:0]             i_avs_address,
   input  wire logic                                   i_avs_read,
   input  wire logic                                   i_avs_write,
   input  wire logic [frf_pkg::DATA_W-1:0]             i_avs_writedata,
   input  wire logic [frf_pkg::BE_W-1:0]               i_avs_byteenable,
   output logic      [frf_pkg::DATA_W-1:0]             o_avs_readdata,
   output logic                                        o_avs_waitrequest,
   // global lock from the first configuration register
   input  wire logic                                   i_cfg_lock,
   // automatic control inputs per drive output
   input  wire logic [frf_pkg::NUM_CH-1:0]             i_auto_mode,
   input  wire logic [frf_pkg::NUM_CH-1:0]             i_below_start,
   input  wire logic [frf_pkg::NUM_CH-1:0][frf_pkg::DUTY_W-1:0] i_calc_duty,
   input  wire logic [frf_pkg::NUM_CH-1:0][frf_pkg::DUTY_W-1:0] i_min_duty,
   // fan drive duty outputs
   output logic      [frf_pkg::DUTY_W-1:0]             o_fan_drive_out_1,
   output logic      [frf_pkg::DUTY_W-1:0]             o_fan_drive_out_2,
   output logic      [frf_pkg::DUTY_W-1:0]             o_fan_drive_out_3,
   // speed inputs 2..4 timed against drive three, bit 0 is input 2
   output logic      [2:0]                             o_speed_sync_sel,
   output logic                                        o_ramp_active
);
   import frf_pkg::*;

   frf_bus_state_t              bus_state;
   logic [7:0]                  cfg;
   logic [DUTY_W-1:0]           target [NUM_CH];
   logic [DUTY_W-1:0]           drive2;
   logic [DUTY_W-1:0]           drive3;
   logic                        bus_req;
   logic                        bus_take;

   frf_ramp_if #(.W(DUTY_W)) rif ();

   // bus slave: one wait state, so read data come from a flop
   assign bus_req           = i_avs_read || i_avs_write;
   assign bus_take          = bus_req && (bus_state == FRF_BUS_ACK);
   assign o_avs_waitrequest = bus_req && (bus_state != FRF_BUS_ACK);

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bus_state <= FRF_BUS_IDLE;
      end else begin
         case (bus_state)
            FRF_BUS_IDLE: begin
               if (bus_req) begin
                  bus_state <= FRF_BUS_ACK;
               end
            end
            FRF_BUS_ACK: begin
               bus_state <= FRF_BUS_IDLE;
            end
            default: begin
               bus_state <= FRF_BUS_IDLE;
            end
         endcase
      end
   end

   // unmapped addresses read zero and swallow writes
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_avs_readdata <= '0;
      end else if (bus_state == FRF_BUS_IDLE && i_avs_read) begin
         if (i_avs_address == CFG_ADDR) begin
            o_avs_readdata <= {24'h000000, cfg};
         end else if (i_avs_address == STAT_ADDR) begin
            o_avs_readdata <= '0;
            o_avs_readdata[STAT_DUTY_LSB +: DUTY_W] <= o_fan_drive_out_1;
            o_avs_readdata[STAT_ACTIVE_BIT]         <= o_ramp_active;
         end else begin
            o_avs_readdata <= '0;
         end
      end
   end

   // locked writes still complete on the bus so software never hangs
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg <= CFG_RESET;                                     // [RQ11]
      end else if (bus_take && i_avs_write && !i_cfg_lock     // [RQ12]
                   && i_avs_address == CFG_ADDR && i_avs_byteenable[0]) begin
         cfg <= i_avs_writedata[7:0];
      end
   end

   // floor select per channel when below start minus hysteresis
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_floor
         always_comb begin
            if (i_auto_mode[g] && i_below_start[g]) begin
               target[g] = cfg[FLOOR_LSB + g] ? i_min_duty[g] : DUTY_OFF; // [RQ8] [RQ9] [RQ10]
            end else begin
               target[g] = i_calc_duty[g];
            end
         end
      end
   endgenerate

   // drive one goes through the ramp stepper
   assign rif.enable = cfg[RAMP_EN_BIT];                          // [RQ4]
   assign rif.step   = frf_step(cfg[RAMP_CODE_LSB +: RAMP_CODE_W]); // [RQ1] [RQ3]
   assign rif.target = target[0];

   frf_slot_timer #(.CYCLES(SLOT_CYCLES)) u_slot (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .o_tick     (rif.tick)
   );

   frf_ramp #(.W(DUTY_W)) u_ramp (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .rif        (rif)
   );

   assign o_fan_drive_out_1 = rif.duty;
   assign o_fan_drive_out_2 = drive2;
   assign o_fan_drive_out_3 = drive3;

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         drive2 <= DUTY_OFF;
         drive3 <= DUTY_OFF;
      end else begin
         drive2 <= target[1];                                  // [RQ9]
         drive3 <= target[2];                                  // [RQ10]
      end
   end

   // inputs three and four always follow drive three
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_speed_sync_sel <= {SYNC_FIXED, 1'b0};
      end else begin
         o_speed_sync_sel <= {SYNC_FIXED, cfg[SYNC_BIT]};      // [RQ6] [RQ7]
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ramp_active <= 1'b0;
      end else begin
         o_ramp_active <= cfg[RAMP_EN_BIT] && (rif.duty != rif.target);
      end
   end

   property p_bus_ack;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      bus_req && bus_state == FRF_BUS_IDLE |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer not after one wait state");

   property p_cfg_write;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      bus_take && i_avs_write && !i_cfg_lock && i_avs_address == CFG_ADDR
      && i_avs_byteenable[0] |=> cfg == $past(i_avs_writedata[7:0]);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // [RQ1]

   property p_lock;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_cfg_lock && bus_take && i_avs_write |=> $stable(cfg);
   endproperty
   a_lock: assert property (p_lock) else $error("locked config changed"); // [RQ12]

   property p_cfg_read;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      bus_state == FRF_BUS_IDLE && i_avs_read && i_avs_address == CFG_ADDR
      |=> o_avs_readdata == {24'h000000, $past(cfg)};
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config read data wrong");

   property p_sync;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      1'b1 |=> o_speed_sync_sel == {SYNC_FIXED, $past(cfg[SYNC_BIT])};
   endproperty
   a_sync: assert property (p_sync) else $error("speed sync select wrong"); // [RQ6]

   property p_floor_off;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_auto_mode[1] && i_below_start[1] && !cfg[FLOOR_LSB + 1] |=> drive2 == DUTY_OFF;
   endproperty
   a_floor_off: assert property (p_floor_off) else $error("drive two not off"); // [RQ9]

   property p_floor_min;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_auto_mode[2] && i_below_start[2] && cfg[FLOOR_LSB + 2]
      |=> drive3 == $past(i_min_duty[2]);
   endproperty
   a_floor_min: assert property (p_floor_min) else $error("drive three not at minimum"); // [RQ10]

   property p_floor_one;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_auto_mode[0] && i_below_start[0] && !cfg[RAMP_EN_BIT]
      |=> o_fan_drive_out_1 == ($past(cfg[FLOOR_LSB]) ? $past(i_min_duty[0]) : DUTY_OFF);
   endproperty
   a_floor_one: assert property (p_floor_one) else $error("drive one floor wrong"); // [RQ8]

   property p_reset_cfg;
      @(posedge i_core_clk) $rose(i_reset_n) |-> cfg == CFG_RESET;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg) else $error("config not zero after reset"); // [RQ11]

   property p_floor_two_min;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_auto_mode[1] && i_below_start[1] && cfg[FLOOR_LSB + 1]
      |=> drive2 == $past(i_min_duty[1]);
   endproperty
   a_floor_two_min: assert property (p_floor_two_min) else $error("drive two not at min"); // [RQ9]

   property p_floor_three_off;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_auto_mode[2] && i_below_start[2] && !cfg[FLOOR_LSB + 2]
      |=> drive3 == DUTY_OFF;
   endproperty
   a_floor_three_off: assert property (p_floor_three_off) else $error("drive three not off"); // [RQ10]

   property p_follow_two;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      !(i_auto_mode[1] && i_below_start[1])
      |=> drive2 == $past(i_calc_duty[1]);
   endproperty
   a_follow_two: assert property (p_follow_two) else $error("drive two lost duty"); // [RQ9]

   property p_follow_three;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      !(i_auto_mode[2] && i_below_start[2])
      |=> drive3 == $past(i_calc_duty[2]);
   endproperty
   a_follow_three: assert property (p_follow_three) else $error("drive three lost duty"); // [RQ10]

   property p_ramp_hold;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      cfg[RAMP_EN_BIT] && !rif.tick
      |=> $stable(o_fan_drive_out_1);
   endproperty
   a_ramp_hold: assert property (p_ramp_hold) else $error("drive one jumped"); // [RQ4]

   property p_bypass_one;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      !cfg[RAMP_EN_BIT]
      |=> o_fan_drive_out_1 == $past(target[0]);
   endproperty
   a_bypass_one: assert property (p_bypass_one) else $error("drive one lagged"); // [RQ5]

   property p_sync_low;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      !cfg[SYNC_BIT]
      |=> o_speed_sync_sel == {SYNC_FIXED, 1'b0};
   endproperty
   a_sync_low: assert property (p_sync_low) else $error("speed input two still timed"); // [RQ7]

   property p_sync_high;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      cfg[SYNC_BIT]
      |=> o_speed_sync_sel == {SYNC_FIXED, 1'b1};
   endproperty
   a_sync_high: assert property (p_sync_high) else $error("speed input two not timed"); // [RQ6]

   property p_write_other;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      bus_take && i_avs_write && i_avs_address != CFG_ADDR
      |=> $stable(cfg);
   endproperty
   a_write_other: assert property (p_write_other) else $error("stray write hit config");

   property p_idle_active;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      !cfg[RAMP_EN_BIT]
      |=> !o_ramp_active;
   endproperty
   a_idle_active: assert property (p_idle_active) else $error("ramp busy while off"); // [RQ4]

   property p_stat_read;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      bus_state == FRF_BUS_IDLE && i_avs_read && i_avs_address == STAT_ADDR
      |=> o_avs_readdata[STAT_DUTY_LSB +: DUTY_W] == $past(o_fan_drive_out_1)
          && o_avs_readdata[STAT_ACTIVE_BIT] == $past(o_ramp_active);
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("status read wrong");

   c_locked_write: cover property (@(posedge i_core_clk) bus_take && i_avs_write && i_cfg_lock);
   c_floor_min: cover property (@(posedge i_core_clk) i_auto_mode[0] && i_below_start[0]
                                && cfg[FLOOR_LSB]);
   c_sync_all: cover property (@(posedge i_core_clk) o_speed_sync_sel == 3'h7);
   c_ramping: cover property (@(posedge i_core_clk) o_ramp_active);

endmodule // frf_top

/* testbench/frf_fan_model.sv */
`timescale 1ns/1ps
module frf_fan_model (
   // clock and drive duty
   input  wire logic        i_core_clk,
   input  wire logic [7:0]  i_duty,
   // fan speed, lags the drive by one cycle like a real rotor would
   output logic      [15:0] o_speed
);
   always_ff @(posedge i_core_clk) begin
      o_speed <= {8'h00, i_duty} * 16'h0014;
   end
endmodule // frf_fan_model

/* testbench/frf_top_bench.sv */
`timescale 1ns/1ps
module frf_top_bench;
   import frf_pkg::*;
   localparam int unsigned SLOTS = 8;
   logic                          i_core_clk;
   logic                          i_reset_n;
   logic [ADDR_W-1:0]             i_avs_address;
   logic                          i_avs_read;
   logic                          i_avs_write;
   logic [DATA_W-1:0]             i_avs_writedata;
   logic [BE_W-1:0]               i_avs_byteenable;
   logic [DATA_W-1:0]             o_avs_readdata;
   logic                          o_avs_waitrequest;
   logic                          i_cfg_lock;
   logic [NUM_CH-1:0]             i_auto_mode;
   logic [NUM_CH-1:0]             i_below_start;
   logic [NUM_CH-1:0][DUTY_W-1:0] i_calc_duty;
   logic [NUM_CH-1:0][DUTY_W-1:0] i_min_duty;
   logic [DUTY_W-1:0]             o_fan_drive_out_1;
   logic [DUTY_W-1:0]             o_fan_drive_out_2;
   logic [DUTY_W-1:0]             o_fan_drive_out_3;
   logic [2:0]                    o_speed_sync_sel;
   logic                          o_ramp_active;
   logic [15:0]                   speed1;
   logic [7:0]                    steps [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                                                8'h08, 8'h0C, 8'h18, 8'h30};
   logic [7:0]                    e;
   logic [31:0]                   bq;
   int                            err_total;
   int                            checked;

   frf_top #(.SLOT_CYCLES(SLOTS)) frf_top_i (
      .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_cfg_lock(i_cfg_lock),
      .i_auto_mode(i_auto_mode), .i_below_start(i_below_start), .i_calc_duty(i_calc_duty),
      .i_min_duty(i_min_duty), .o_fan_drive_out_1(o_fan_drive_out_1),
      .o_fan_drive_out_2(o_fan_drive_out_2), .o_fan_drive_out_3(o_fan_drive_out_3),
      .o_speed_sync_sel(o_speed_sync_sel), .o_ramp_active(o_ramp_active));

   frf_fan_model frf_fan_model_i (.i_core_clk(i_core_clk), .i_duty(o_fan_drive_out_1),
      .o_speed(speed1));

   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask

   // request held until waitrequest is sampled low; the next call waits an edge first
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge i_core_clk);
      i_avs_address <= a;
      i_avs_write <= wr;
      i_avs_read <= ~wr;
      i_avs_writedata <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      chk("bus answer edges", 32'd2, n);
   endtask

   task automatic wr(input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, CFG_ADDR, d, q);
   endtask

   task automatic rd_chk(input string w, input logic [ADDR_W-1:0] a, input logic [7:0] x);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(w, {24'h000000, x}, q);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask

   task automatic wait_change;
      int n;
      logic [7:0] p;
      p = o_fan_drive_out_1;
      n = 0;
      do begin
         settle(1);
         n++;
      end while (o_fan_drive_out_1 === p && n < 40);
   endtask

   initial begin
      repeat (20000) @(posedge i_core_clk);
      err_total++;
      print_verdict();
   end

   initial begin
      err_total = 0;
      checked = 0;
      i_reset_n = 1'b0;
      i_avs_address = '0;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_writedata = '0;
      i_avs_byteenable = 4'hF;
      i_cfg_lock = 1'b0;
      i_auto_mode = 3'h0;
      i_below_start = 3'h0;
      i_calc_duty = '0;
      i_min_duty = '0;
      repeat (16) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      rd_chk("cfg reset", CFG_ADDR, 8'h00);
      settle(1);
      chk("sync reset", 32'h6, {29'h0, o_speed_sync_sel});
      wr(8'h10);
      settle(2);
      chk("sync set", 32'h7, {29'h0, o_speed_sync_sel});
      rd_chk("cfg back", CFG_ADDR, 8'h10);
      wr(8'h00);
      settle(2);
      chk("sync clr", 32'h6, {29'h0, o_speed_sync_sel});
      rd_chk("unmapped", 10'h000, 8'h00);
      bus(1'b1, STAT_ADDR, 8'hFF, bq);
      rd_chk("cfg after stray", CFG_ADDR, 8'h00);
      $display("test registers done");
      // ramp off: every output follows its new duty one edge later
      @(posedge i_core_clk);
      i_calc_duty <= {8'h33, 8'h22, 8'h11};
      settle(1);
      chk("drive1 direct", 32'h11, {24'h0, o_fan_drive_out_1});
      chk("drive2 direct", 32'h22, {24'h0, o_fan_drive_out_2});
      chk("drive3 direct", 32'h33, {24'h0, o_fan_drive_out_3});
      rd_chk("status", STAT_ADDR, 8'h11);
      $display("test direct done");
      @(posedge i_core_clk);
      i_auto_mode <= 3'h7;
      i_below_start <= 3'h7;
      i_min_duty <= {8'h30, 8'h20, 8'h10};
      for (int f = 0; f < 8; f++) begin
         wr({f[2:0], 5'h00});
         settle(2);
         e = f[0] ? 8'h10 : 8'h00;
         chk("drive1 floor", {24'h0, e}, {24'h0, o_fan_drive_out_1});
         chk("fan1 speed", {16'h0, {8'h00, e} * 16'h0014}, {16'h0, speed1});
         chk("drive2 floor", f[1] ? 32'h20 : 32'h0, {24'h0, o_fan_drive_out_2});
         chk("drive3 floor", f[2] ? 32'h30 : 32'h0, {24'h0, o_fan_drive_out_3});
      end
      @(posedge i_core_clk);
      i_auto_mode <= 3'h0;
      i_below_start <= 3'h0;
      $display("test floor done");
      for (int c = 0; c < 8; c++) begin
         wr(8'h00);
         @(posedge i_core_clk);
         i_calc_duty[0] <= 8'h00;
         settle(2);
         wr({5'h01, c[2:0]});
         @(posedge i_core_clk);
         i_calc_duty[0] <= 8'd50;
         wait_change();
         chk("ramp first", {24'h0, steps[c]}, {24'h0, o_fan_drive_out_1});
         chk("ramp busy", 32'h1, {31'h0, o_ramp_active});
         wait_change();
         e = (steps[c] > 8'd25) ? 8'd50 : steps[c] * 8'h02;
         chk("ramp second", {24'h0, e}, {24'h0, o_fan_drive_out_1});
      end
      $display("test ramp done");
      wr(8'hA5);
      @(posedge i_core_clk);
      i_cfg_lock <= 1'b1;
      wr(8'h5A);
      rd_chk("cfg locked", CFG_ADDR, 8'hA5);
      @(posedge i_core_clk);
      i_cfg_lock <= 1'b0;
      wr(8'h5A);
      rd_chk("cfg unlocked", CFG_ADDR, 8'h5A);
      $display("test lock done");
      print_verdict();
   end
endmodule // frf_top_bench
